// file: rtl/codec_fault_params.svh
`ifndef CODEC_FAULT_PARAMS_SVH
`define CODEC_FAULT_PARAMS_SVH

// register offsets on the control port
`define ADDR_INTERRUPT_SETUP 8'h1E
`define ADDR_FAULT_MASK_FIRST 8'h1F
`define ADDR_FAULT_MASK_SECOND 8'h20
`define ADDR_FAULT_FLAGS_FIRST 8'h21
`define ADDR_FAULT_FLAGS_SECOND 8'h22

// interrupt_setup fields
`define SETUP_AUTOSET_BIT 7
`define SETUP_POL_HI 6
`define SETUP_POL_LO 5
`define SETUP_USED_MASK 8'hE0

// first and second mask / flag register fields
`define FIRST_TEST_BIT 7
`define FIRST_SERIAL_BIT 6
`define FIRST_CLOCK_BIT 5
`define FIRST_USED_MASK 8'hEF
`define SECOND_USED_MASK 8'h1F

// reset values: everything masked, autoset on, active high
`define RESET_SETUP 8'h00
`define RESET_MASK_FIRST 8'hEF
`define RESET_MASK_SECOND 8'h1F
`define RESET_FLAGS 8'h00

// powered down when all converter power-down bits are set
`define ALL_POWERED_DOWN 8'hFF

`endif

// file: rtl/codec_fault_pkg.sv
package codec_fault_pkg;

    typedef enum logic [1:0] {
        POL_ACTIVE_HIGH,
        POL_ACTIVE_LOW,
        POL_OPEN_DRAIN,
        POL_RESERVED
    } irq_pin_polarity_e;

    // raw fault events, one-cycle pulses from the detectors
    typedef struct packed {
        logic test_state_fault;
        logic [3:0] converter_overrange;
        logic [4:0] output_saturation;
    } fault_events_s;

    // control-port configuration watched for serial faults
    typedef struct packed {
        logic [1:0] serial_format_field;
        logic [1:0] rate_range_field;
        logic [7:0] clock_ratio;
        logic [7:0] power_down_bits;
    } port_config_s;

endpackage : codec_fault_pkg

// file: rtl/codec_fault_interrupt_unit.sv
`timescale 1ns/1ps
`include "codec_fault_params.svh"
module codec_fault_interrupt_unit (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // control port register access
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // fault sources
    input wire codec_fault_pkg::fault_events_s events_i,
    input wire codec_fault_pkg::port_config_s config_i,
    // interrupt pin
    output logic irq_o,
    output logic irq_oe_o
);

    logic [7:0] interrupt_setup;
    logic [7:0] fault_mask_first;
    logic [7:0] fault_mask_second;
    logic [7:0] fault_flags_first;
    logic [7:0] fault_flags_second;
    codec_fault_pkg::port_config_s config_prev;
    logic config_valid;
    logic [7:0] next_set_first;
    logic [7:0] next_set_second;
    logic serial_change;
    logic ratio_change;
    logic powered_up;
    logic rd_first;
    logic rd_second;
    logic irq_active;
    codec_fault_pkg::irq_pin_polarity_e pol;

    // decoded strobes and next values
    logic wr_setup;
    logic wr_mask_first;
    logic wr_mask_second;
    logic autoset_on;
    logic [7:0] next_rdata;
    logic next_irq;
    logic next_irq_oe;

    ////////////////////////////////////////////////////////////////////////
    // fault detection

    // watched fields as they stood one cycle ago
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            config_prev <= '0;
            config_valid <= 1'b0;
        end else begin
            config_prev <= config_i;
            config_valid <= 1'b1;
        end
    end

    // first cycle after reset has no history, so no change is reported
    always_comb begin
        powered_up = config_i.power_down_bits != `ALL_POWERED_DOWN;
        serial_change = config_valid && powered_up &&
            ((config_i.serial_format_field !=
              config_prev.serial_format_field) ||
             (config_i.rate_range_field != config_prev.rate_range_field));
        ratio_change = config_valid && powered_up &&
            (config_i.clock_ratio != config_prev.clock_ratio);
        next_set_first = 8'h00;
        next_set_first[`FIRST_TEST_BIT] = events_i.test_state_fault;
        // a ratio change also upsets the serial framing
        next_set_first[`FIRST_SERIAL_BIT] =
            serial_change || ratio_change;
        next_set_first[`FIRST_CLOCK_BIT] = ratio_change;
        next_set_first[3:0] = events_i.converter_overrange;
        next_set_second = {3'h0, events_i.output_saturation};
    end

    ////////////////////////////////////////////////////////////////////////
    // register access

    assign rd_first = reg_rd_i && (reg_addr_i == `ADDR_FAULT_FLAGS_FIRST);
    assign rd_second = reg_rd_i && (reg_addr_i == `ADDR_FAULT_FLAGS_SECOND);
    assign wr_setup = reg_wr_i && (reg_addr_i == `ADDR_INTERRUPT_SETUP);
    assign wr_mask_first = reg_wr_i &&
        (reg_addr_i == `ADDR_FAULT_MASK_FIRST);
    assign wr_mask_second = reg_wr_i &&
        (reg_addr_i == `ADDR_FAULT_MASK_SECOND);
    // autoset is the default mode, select bit low
    assign autoset_on = !interrupt_setup[`SETUP_AUTOSET_BIT];

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            interrupt_setup <= `RESET_SETUP;
        end else if (wr_setup) begin
            interrupt_setup <= reg_wdata_i & `SETUP_USED_MASK;
        end
    end

    // a host write in the same cycle as an autoset read wins
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fault_mask_first <= `RESET_MASK_FIRST;
        end else if (wr_mask_first) begin
            fault_mask_first <= reg_wdata_i & `FIRST_USED_MASK;
        end else if (rd_first && autoset_on) begin
            // only the flags returned by this read get masked
            fault_mask_first <= fault_mask_first | fault_flags_first;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fault_mask_second <= `RESET_MASK_SECOND;
        end else if (wr_mask_second) begin
            fault_mask_second <= reg_wdata_i & `SECOND_USED_MASK;
        end else if (rd_second && autoset_on) begin
            fault_mask_second <= fault_mask_second | fault_flags_second;
        end
    end

    // writes to the flag registers are ignored; set wins over read clear
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fault_flags_first <= `RESET_FLAGS;
        end else begin
            fault_flags_first <= ((rd_first ? 8'h00 : fault_flags_first) |
                next_set_first) & `FIRST_USED_MASK;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fault_flags_second <= `RESET_FLAGS;
        end else begin
            fault_flags_second <= ((rd_second ? 8'h00 : fault_flags_second) |
                next_set_second) & `SECOND_USED_MASK;
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        if (reg_addr_i == `ADDR_INTERRUPT_SETUP) begin
            next_rdata = interrupt_setup;
        end else if (reg_addr_i == `ADDR_FAULT_MASK_FIRST) begin
            next_rdata = fault_mask_first;
        end else if (reg_addr_i == `ADDR_FAULT_MASK_SECOND) begin
            next_rdata = fault_mask_second;
        end else if (reg_addr_i == `ADDR_FAULT_FLAGS_FIRST) begin
            next_rdata = fault_flags_first;
        end else if (reg_addr_i == `ADDR_FAULT_FLAGS_SECOND) begin
            next_rdata = fault_flags_second;
        end else begin
            next_rdata = 8'h00;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pin

    // a mask bit of 1 keeps its flag off the pin
    assign irq_active = |(fault_flags_first & ~fault_mask_first) |
        |(fault_flags_second & ~fault_mask_second);
    assign pol = codec_fault_pkg::irq_pin_polarity_e'(
        interrupt_setup[`SETUP_POL_HI:`SETUP_POL_LO]);

    // reserved polarity code behaves as active high
    always_comb begin
        case (pol)
            codec_fault_pkg::POL_ACTIVE_LOW: begin
                next_irq = !irq_active;
                next_irq_oe = 1'b1;
            end
            // open drain only ever pulls low, so the enable carries the state
            codec_fault_pkg::POL_OPEN_DRAIN: begin
                next_irq = 1'b0;
                next_irq_oe = irq_active;
            end
            default: begin
                next_irq = irq_active;
                next_irq_oe = 1'b1;
            end
        endcase
    end

    // registered so the pin never glitches while flags and masks settle
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
            irq_oe_o <= 1'b1;
        end else begin
            irq_o <= next_irq;
            irq_oe_o <= next_irq_oe;
        end
    end

endmodule : codec_fault_interrupt_unit

// file: sim/codec_fault_interrupt_unit_assertions.sv
`timescale 1ns/1ps
module codec_fault_interrupt_unit_assertions (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // faults and pin
    input wire codec_fault_pkg::fault_events_s events_i,
    input wire codec_fault_pkg::port_config_s config_i,
    input wire logic irq_o,
    input wire logic irq_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    a_setup_reserved: assert property (
        reg_rd_i && reg_addr_i == 8'h1E |=> reg_rdata_o[4:0] == 5'h00)
        else $error("setup reserved bits read nonzero");
    a_mask1_reserved: assert property (
        reg_rd_i && reg_addr_i == 8'h1F |=> !reg_rdata_o[4])
        else $error("first mask reserved bit set");
    a_mask2_reserved: assert property (
        reg_rd_i && reg_addr_i == 8'h20 |=> reg_rdata_o[7:5] == 3'h0)
        else $error("second mask reserved bits set");
    a_flags2_reserved: assert property (
        reg_rd_i && reg_addr_i == 8'h22 |=> reg_rdata_o[7:5] == 3'h0)
        else $error("second flags reserved bits set");
    a_test_fault_seen: assert property (
        events_i.test_state_fault ##1 (reg_rd_i && reg_addr_i == 8'h21)
        |=> reg_rdata_o[7]) else $error("test state fault not recorded");
    a_serial_fault_seen: assert property (
        ($changed(config_i.serial_format_field)
        && config_i.power_down_bits != 8'hFF)
        ##1 (reg_rd_i && reg_addr_i == 8'h21) |=> reg_rdata_o[6])
        else $error("serial fault not recorded");
    a_ratio_fault_seen: assert property (
        ($changed(config_i.clock_ratio) && config_i.power_down_bits != 8'hFF)
        ##1 (reg_rd_i && reg_addr_i == 8'h21) |=> reg_rdata_o[6:5] == 2'h3)
        else $error("ratio change did not raise both faults");
    a_drain_released: assert property (
        !irq_oe_o |-> !irq_o) else $error("pin driven high while released");
endmodule : codec_fault_interrupt_unit_assertions

// file: sim/codec_host_model.sv
`timescale 1ns/1ps
module codec_host_model (
    // clock
    input wire logic mclk_i,
    // register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    // interrupt pin
    input wire logic irq_i,
    input wire logic irq_oe_i,
    output logic pin_o
);
    // board pull-up holds the line high when released
    assign pin_o = irq_oe_i ? irq_i : 1'h1;
    initial begin
        reg_wr_o = 1'h0;
        reg_rd_o = 1'h0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // idle cycle after each access so strobes never toggle in one step
    task automatic access(input logic wr, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q);
        reg_wr_o = wr;
        reg_rd_o = !wr;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge mclk_i);
        #1;
        q = reg_rdata_i;
        reg_wr_o = 1'h0;
        reg_rd_o = 1'h0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
        @(posedge mclk_i);
        #1;
    endtask : access
endmodule : codec_host_model

// file: sim/codec_fault_interrupt_unit_tb_top.sv
`timescale 1ns/1ps
`include "codec_fault_params.svh"
module codec_fault_interrupt_unit_tb_top;
    logic mclk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic reg_wr, reg_rd, irq, irq_oe, pin;
    logic [7:0] addr, wdata, rdata, q;
    codec_fault_pkg::fault_events_s ev = '0;
    codec_fault_pkg::port_config_s cfg = '0;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #4 mclk_i = ~mclk_i;
    codec_fault_interrupt_unit uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .events_i(ev),
        .config_i(cfg), .irq_o(irq), .irq_oe_o(irq_oe));
    codec_host_model host (.mclk_i(mclk_i), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_rdata_i(rdata), .irq_i(irq), .irq_oe_i(irq_oe), .pin_o(pin));
    ////////////////////////////////////////////////////////////////////////
    task step; @(posedge mclk_i); #1; endtask : step
    task wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'h1, a, d, q);
    endtask : wr
    task fire(input codec_fault_pkg::fault_events_s e);
        ev = e;
        step;
        ev = '0;
    endtask : fire
    task chk_reg(input logic [7:0] a, input logic [7:0] exp);
        host.access(1'h0, a, 8'h00, q);
        n_compared++;
        if (q !== exp) begin
            fail_count++;
            $display("unexpected %0t: reg %h read %h not %h", $time, a, q, exp);
        end
    endtask : chk_reg
    task chk_pin(input logic exp);
        n_compared++;
        if (pin !== exp) begin
            fail_count++;
            $display("unexpected %0t: pin %b not %b", $time, pin, exp);
        end
    endtask : chk_pin
    task give_verdict;
        $display("mismatches %0d, compared %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk_reg(8'h1E, `RESET_SETUP);
        chk_reg(8'h1F, `RESET_MASK_FIRST);
        chk_reg(8'h20, `RESET_MASK_SECOND);
        chk_reg(8'h22, `RESET_FLAGS);
        chk_reg(8'h30, 8'h00);
        wr(8'h21, 8'hFF);
        chk_reg(8'h21, 8'h00);
    endtask : t_reset
    task t_autoset;
        wr(8'h1F, 8'h00);
        fire(10'h020);
        step;
        chk_pin(1'h1);
        chk_reg(8'h21, 8'h01);
        chk_pin(1'h0);
        chk_reg(8'h1F, 8'h01);
        chk_reg(8'h21, 8'h00);
    endtask : t_autoset
    task t_polarity;
        wr(8'h1F, 8'h00);
        for (int p = 0; p < 4; p++) begin
            wr(8'h1E, {1'h1, p[1:0], 5'h1F});
            chk_reg(8'h1E, {1'h1, p[1:0], 5'h00});
            chk_pin(p == 1 || p == 2);
            fire(10'h040);
            step;
            chk_pin(p == 0 || p == 3);
            chk_reg(8'h21, 8'h02);
            chk_reg(8'h1F, 8'h00);
        end
        fire(10'h010);
        chk_reg(8'h22, 8'h10);
    endtask : t_polarity
    task t_second;
        wr(8'h1E, 8'h00);
        wr(8'h20, 8'hE0);
        chk_reg(8'h20, 8'h00);
        fire(10'h001);
        step;
        chk_pin(1'h1);
        chk_reg(8'h22, 8'h01);
        chk_reg(8'h20, 8'h01);
        fire(10'h001);
        step;
        chk_pin(1'h0);
        chk_reg(8'h22, 8'h01);
    endtask : t_second
    task t_config;
        cfg.serial_format_field = 2'h1;
        step;
        chk_reg(8'h21, 8'h40);
        cfg.rate_range_field = 2'h1;
        step;
        chk_reg(8'h21, 8'h40);
        cfg.clock_ratio = 8'h10;
        step;
        chk_reg(8'h21, 8'h60);
        cfg.power_down_bits = 8'hFF;
        step;
        cfg.serial_format_field = 2'h2;
        step;
        chk_reg(8'h21, 8'h00);
        fire(10'h200);
        chk_reg(8'h21, 8'h80);
    endtask : t_config
    // ceiling well above the hundred or so cycles the scenarios need
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        #1;
        rst_n_i = 1'h1;
        t_reset;
        t_autoset;
        t_polarity;
        t_second;
        t_config;
        give_verdict;
    end
endmodule : codec_fault_interrupt_unit_tb_top
bind codec_fault_interrupt_unit codec_fault_interrupt_unit_assertions chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .events_i(events_i), .config_i(config_i),
    .irq_o(irq_o), .irq_oe_o(irq_oe_o));
